//--- rtl/sirc_codec.sv
// sir pulse encoder and decoder between a uart and an optical transceiver
`timescale 1ns/1ps
`default_nettype none
`include "sirc_params.svh"
module sirc_codec (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic codec_reset,
  input wire logic oversample_clock,
  input wire logic uart_tx_in,
  input wire logic optical_pulse_in,
  output logic optical_pulse_out,
  output logic uart_rx_out
);
  sirc_sync_if #(.WIDTH(`SIRC_SYNC_WIDTH)) sync_bus ();
  // bit 3 reset, 2 uart tx, 1 optical in, 0 oversample clock
  assign sync_bus.raw = {codec_reset, uart_tx_in, optical_pulse_in, oversample_clock};
  sirc_sync #(
    .WIDTH(`SIRC_SYNC_WIDTH),
    .RESET_VAL(`SIRC_SYNC_RESET)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pins(sync_bus)
  );
  logic rst_s;
  logic tx_s;
  logic ir_s;
  logic ovs_s;
  assign rst_s = sync_bus.synced[3];
  assign tx_s = sync_bus.synced[2];
  assign ir_s = sync_bus.synced[1];
  assign ovs_s = sync_bus.synced[0];

  // edge detection on the sampled oversample clock and optical input
  logic ovs_d_reg;
  logic ir_d_reg;
  logic ovs_fall;
  logic ovs_rise;
  logic ir_fall;
  assign ovs_fall = ovs_d_reg & ~ovs_s;
  assign ovs_rise = ~ovs_d_reg & ovs_s;
  // only falling edges count, so positive pulses decode at their tail
  assign ir_fall = ir_d_reg & ~ir_s;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovs_d_reg <= 1'b0;
      ir_d_reg <= 1'b1;
    end else begin
      ovs_d_reg <= ovs_s;
      ir_d_reg <= ir_s;
    end
  end

  // encoder: counter of oversample falling edges since transmit went low
  logic [3:0] enc_cnt_reg;
  logic [3:0] enc_cnt_next;
  logic tx_out_reg;
  logic tx_out_next;
  always_comb begin
    enc_cnt_next = enc_cnt_reg;
    tx_out_next = tx_out_reg;
    if (rst_s) begin
      enc_cnt_next = 4'h0;
      tx_out_next = 1'b0;
    end else if (tx_s) begin
      enc_cnt_next = 4'h0;
      tx_out_next = 1'b0;
    end else if (ovs_fall) begin
      // 4-bit wrap gives the sixteen-clock bit period with no extra compare
      enc_cnt_next = enc_cnt_reg + 4'h1;
      tx_out_next = (enc_cnt_next >= `SIRC_PULSE_START) &&
                    (enc_cnt_next < `SIRC_PULSE_END);
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enc_cnt_reg <= 4'h0;
      tx_out_reg <= 1'b0;
    end else begin
      enc_cnt_reg <= enc_cnt_next;
      tx_out_reg <= tx_out_next;
    end
  end
  assign optical_pulse_out = tx_out_reg;

  // decoder: edge pending until next rising oversample edge, then sixteen low cycles
  sirc_pkg::sirc_rx_state_type dec_state_reg;
  sirc_pkg::sirc_rx_state_type dec_state_next;
  logic [3:0] dec_cnt_reg;
  logic [3:0] dec_cnt_next;
  logic pend_reg;
  logic pend_next;
  logic rx_out_reg;
  logic rx_out_next;
  always_comb begin
    dec_state_next = dec_state_reg;
    dec_cnt_next = dec_cnt_reg;
    pend_next = pend_reg;
    rx_out_next = rx_out_reg;
    if (rst_s) begin
      dec_state_next = sirc_pkg::SIRC_RX_IDLE;
      dec_cnt_next = 4'h0;
      pend_next = 1'b0;
      rx_out_next = 1'b1;
    end else begin
      if (ovs_rise) begin
        if (pend_reg) begin
          // a restart at the sixteenth edge keeps the line low across zeros
          dec_state_next = sirc_pkg::SIRC_RX_LOW;
          dec_cnt_next = 4'h0;
          rx_out_next = 1'b0;
        end else begin
          unique case (dec_state_reg)
            sirc_pkg::SIRC_RX_IDLE: begin
              rx_out_next = 1'b1;
            end
            sirc_pkg::SIRC_RX_LOW: begin
              dec_cnt_next = dec_cnt_reg + 4'h1;
              if (dec_cnt_reg == `SIRC_RX_LAST) begin
                dec_state_next = sirc_pkg::SIRC_RX_IDLE;
                rx_out_next = 1'b1;
              end
            end
          endcase
        end
        pend_next = 1'b0;
      end
      // a new edge wins over consumption in the same cycle
      if (ir_fall) begin
        pend_next = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dec_state_reg <= sirc_pkg::SIRC_RX_IDLE;
      dec_cnt_reg <= 4'h0;
      pend_reg <= 1'b0;
      rx_out_reg <= 1'b1;
    end else begin
      dec_state_reg <= dec_state_next;
      dec_cnt_reg <= dec_cnt_next;
      pend_reg <= pend_next;
      rx_out_reg <= rx_out_next;
    end
  end
  assign uart_rx_out = rx_out_reg;

  a_tx_idle_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_s |=> (!tx_out_reg && enc_cnt_reg == 4'h0))
    else $error("optical output or counter not idle while transmit high");
  a_tx_rise_seven: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && !tx_s && ovs_fall && enc_cnt_reg == 4'h6) |=> tx_out_reg)
    else $error("pulse did not start at seventh falling edge");
  a_tx_fall_ten: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && !tx_s && ovs_fall && enc_cnt_reg == 4'h9) |=> !tx_out_reg)
    else $error("pulse did not end at tenth falling edge");
  a_pulse_start_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(tx_out_reg) |-> enc_cnt_reg == `SIRC_PULSE_START)
    else $error("pulse began outside clock seven");
  a_pulse_window: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_out_reg |-> (enc_cnt_reg >= 4'h7 && enc_cnt_reg <= 4'h9))
    else $error("pulse active outside clocks seven to ten");
  a_reset_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rst_s |=> (!tx_out_reg && enc_cnt_reg == 4'h0 && rx_out_reg && dec_cnt_reg == 4'h0))
    else $error("reset did not initialise codec");
  a_rx_drop_next: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && ovs_rise && pend_reg) |=> (!rx_out_reg && dec_cnt_reg == 4'h0))
    else $error("receive output did not drop at rising edge");
  a_rx_low_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && ovs_rise && !pend_reg && !rx_out_reg && dec_cnt_reg == 4'hF) |=> rx_out_reg)
    else $error("receive output not released after sixteen cycles");
  a_rx_hold_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && !rx_out_reg && !(ovs_rise && dec_cnt_reg == 4'hF)) |=> !rx_out_reg)
    else $error("receive output rose early");
  a_rx_idle_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_out_reg && !pend_reg) |=> rx_out_reg)
    else $error("receive output fell without an optical edge");
  // a pulse cut by transmit high or codec reset ends with the counter cleared, any other at fall ten
  a_pulse_end_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ($fell(tx_out_reg) && enc_cnt_reg != 4'h0) |-> enc_cnt_reg == `SIRC_PULSE_END)
    else $error("pulse ended outside clock ten");
  a_bit_period_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && !tx_s && ovs_fall && enc_cnt_reg == 4'hF) |=> enc_cnt_reg == 4'h0)
    else $error("encoder counter did not wrap after sixteen clocks");
  a_dec_idle_state: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (dec_state_reg == sirc_pkg::SIRC_RX_IDLE) |-> (rx_out_reg && dec_cnt_reg == 4'h0))
    else $error("idle decoder not high with cleared counter");
  a_dec_reset_state: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rst_s |=> (dec_state_reg == sirc_pkg::SIRC_RX_IDLE && !pend_reg))
    else $error("reset did not return decoder to idle");
  a_rx_restart_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!rst_s && ovs_rise && pend_reg && dec_state_reg == sirc_pkg::SIRC_RX_LOW) |=>
    (dec_state_reg == sirc_pkg::SIRC_RX_LOW && !rx_out_reg))
    else $error("on-time edge did not keep receive output low");
  c_tx_pulse: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(tx_out_reg));
  c_rx_zero: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(rx_out_reg));
  c_rx_back_to_back: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ovs_rise && pend_reg && !rx_out_reg && dec_cnt_reg == 4'hF);
  c_tx_cut: cover property (@(posedge clk_sys) disable iff (!arst_n)
    tx_s && tx_out_reg);
endmodule : sirc_codec
`default_nettype wire

//--- rtl/sirc_params.svh
// timing constants and reset values for the sir pulse codec
`ifndef SIRC_PARAMS_SVH
`define SIRC_PARAMS_SVH
`define SIRC_BIT_CLOCKS 16
`define SIRC_PULSE_START 4'h7
`define SIRC_PULSE_END 4'hA
`define SIRC_RX_LAST 4'hF
`define SIRC_SYNC_WIDTH 4
`define SIRC_SYNC_RESET 4'hE
`define SIRC_SYS_CLK_KHZ 250000
`define SIRC_OVS_MAX_KHZ 1843
`define SIRC_MIN_PULSE_NS 1600
`define SIRC_MIN_PULSE_CYCLES ((`SIRC_MIN_PULSE_NS * (`SIRC_SYS_CLK_KHZ / 1000) + 999) / 1000)
`endif

//--- rtl/sirc_pkg.sv
// types shared by the sir pulse codec
package sirc_pkg;
  typedef enum logic {SIRC_RX_IDLE, SIRC_RX_LOW} sirc_rx_state_type;
endpackage : sirc_pkg

//--- rtl/sirc_sync_if.sv
// interface between pin synchroniser and codec core
`timescale 1ns/1ps
`default_nettype none
interface sirc_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface : sirc_sync_if
`default_nettype wire

//--- rtl/sirc_sync.sv
// two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sirc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  sirc_sync_if.sync pins
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pins.raw;
      stage2_reg <= stage1_reg;
    end
  end
  assign pins.synced = stage2_reg;
endmodule : sirc_sync
`default_nettype wire

//--- bench/sirc_xcvr_model.sv
// baud clock source and optical transceiver model for the codec
`timescale 1ns/1ps
`default_nettype none
module sirc_xcvr_model #(
  parameter int OVS_HALF_NS = 272
) (
  output logic oversample_clock,
  input wire logic led_drive,
  input wire logic invert_rx,
  output logic optical_pulse_in
);
  // free running like a uart baud output, just under the top rate
  initial oversample_clock = 1'b0;
  always #(OVS_HALF_NS) oversample_clock = ~oversample_clock;
  // own light looped back; most photodiode stages invert it
  always_comb optical_pulse_in = led_drive ^ invert_rx;
endmodule : sirc_xcvr_model
`default_nettype wire

//--- bench/sir_pulse_codec_test.sv
// self-checking testbench for the sir pulse codec
`timescale 1ns/1ps
`default_nettype none
module sir_pulse_codec_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic codec_reset = 1'b0;
  logic uart_tx_in = 1'b1;
  logic invert_rx = 1'b1;
  logic oversample_clock, optical_pulse_in, optical_pulse_out, uart_rx_out;
  int bad_count = 0;
  int n_compared = 0;

  always #2 clk_sys = ~clk_sys;

  sirc_xcvr_model xcvr_u (.oversample_clock(oversample_clock), .led_drive(optical_pulse_out),
    .invert_rx(invert_rx), .optical_pulse_in(optical_pulse_in));
  sirc_codec dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .codec_reset(codec_reset),
    .oversample_clock(oversample_clock), .uart_tx_in(uart_tx_in),
    .optical_pulse_in(optical_pulse_in), .optical_pulse_out(optical_pulse_out),
    .uart_rx_out(uart_rx_out));

  task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // sample well after the 3-flop path from the pins has settled
  task settle;
    #24;
  endtask : settle

  task drive_tx(input logic v);
    @(posedge clk_sys);
    #1 uart_tx_in = v;
  endtask : drive_tx

  // aligned so the next oversample fall is fall number one
  task tx_drop;
    @(negedge oversample_clock);
    drive_tx(1'b0);
  endtask : tx_drop

  task t_reset_mid;
    tx_drop;
    repeat (8) @(negedge oversample_clock);
    settle;
    check(optical_pulse_out, 1'b1, "pulse missing before reset");
    check(uart_rx_out, 1'b0, "inverted pulse not decoded");
    @(posedge clk_sys);
    #1 codec_reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check(optical_pulse_out, 1'b0, "pulse kept in reset");
    check(uart_rx_out, 1'b1, "rx low in reset");
    repeat (4) @(posedge clk_sys);
    #1 uart_tx_in = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 codec_reset = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : t_reset_mid

  task t_idle;
    repeat (34) begin
      @(negedge oversample_clock);
      settle;
      check(optical_pulse_out, 1'b0, "pulse while tx high");
      check(uart_rx_out, 1'b1, "rx low with no edges");
    end
  endtask : t_idle

  task t_encode(input int nbits);
    tx_drop;
    for (int b = 0; b <= nbits; b++) begin
      for (int f = 1; f <= 16; f++) begin
        @(negedge oversample_clock);
        settle;
        check(optical_pulse_out, 8'(f >= 7 && f < 10), "pulse timing");
        if (b == nbits && f == 8) begin
          drive_tx(1'b1);
          repeat (4) @(posedge clk_sys);
          #1 check(optical_pulse_out, 1'b0, "tx high did not cut pulse");
          repeat (40) @(posedge oversample_clock);
          return;
        end
      end
    end
  endtask : t_encode

  task t_decode(input int nbits, input logic inv);
    int lows;
    lows = 0;
    tx_drop;
    fork
      begin
        repeat (16 * nbits) @(negedge oversample_clock);
        drive_tx(1'b1);
      end
      begin
        do begin
          @(posedge oversample_clock);
          settle;
          lows++;
        end while (uart_rx_out !== 1'b0 && lows < 40);
        check(optical_pulse_out, inv, "rx fell at wrong point of pulse");
        lows = 0;
        do begin
          @(posedge oversample_clock);
          settle;
          lows++;
          if (lows % 16 == 8) check(uart_rx_out, 1'b0, "mid-bit strobe saw a one");
        end while (uart_rx_out !== 1'b1 && lows < 100);
        check(8'(lows), 8'(16 * nbits), "rx low length");
      end
    join
    repeat (4) @(negedge oversample_clock);
  endtask : t_decode

  // with the led dark, flipping the receiver polarity makes one clean falling edge
  task rx_edge;
    @(negedge oversample_clock);
    @(posedge clk_sys);
    #1 invert_rx = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 invert_rx = 1'b0;
  endtask : rx_edge

  // zeros on time keep the line low; an edge one clock late leaves a one-clock high
  task t_glitch;
    rx_edge;
    repeat (15) @(negedge oversample_clock);
    rx_edge;
    check(uart_rx_out, 1'b0, "first zero ended early");
    @(posedge oversample_clock);
    settle;
    check(uart_rx_out, 1'b0, "gap between on-time zeros");
    repeat (16) @(negedge oversample_clock);
    rx_edge;
    check(uart_rx_out, 1'b1, "no release before late edge");
    @(posedge oversample_clock);
    settle;
    check(uart_rx_out, 1'b0, "late edge not decoded");
    repeat (20) @(posedge oversample_clock);
    settle;
    check(uart_rx_out, 1'b1, "line not idle after zeros");
  endtask : t_glitch

  initial begin
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check(optical_pulse_out, 1'b0, "tx out after reset");
    check(uart_rx_out, 1'b1, "rx out after reset");
    t_reset_mid;
    t_idle;
    t_decode(1, 1'b1);
    t_decode(2, 1'b1);
    t_encode(2);
    t_encode(1);
    // polarity switch itself is a falling edge; let it decode out
    @(posedge clk_sys);
    #1 invert_rx = 1'b0;
    repeat (40) @(negedge oversample_clock);
    t_decode(2, 1'b0);
    t_glitch;
    test_done;
  end

  // about 1.4 times the expected run
  initial begin
    #300000;
    bad_count++;
    test_done;
  end
endmodule : sir_pulse_codec_test
`default_nettype wire
